// ### logic/ssr_status_request.v
`timescale 1ns/1ps
`include "ssr_regs.vh"
module ssr_status_request (
  input  wire       i_ref_clk,
  input  wire       i_rst,
  input  wire       i_new_reading,
  input  wire       i_sensor_over_range,
  input  wire       i_temperature_over_range,
  input  wire       i_sensor_under_range,
  input  wire       i_temperature_under_range,
  input  wire       i_alarm_active,
  input  wire       i_instrument_fault,
  input  wire       i_log_done,
  input  wire       i_command_fault_flag,
  input  wire       i_execution_fault_flag,
  input  wire       i_device_fault_flag,
  input  wire       i_query_fault_flag,
  input  wire       i_operation_complete_cmd,
  input  wire       i_pending_done,
  input  wire       i_request_enable_write_cmd,
  input  wire       i_event_enable_write_cmd,
  input  wire [7:0] i_write_data,
  input  wire       i_serial_poll,
  input  wire       i_status_byte_query_cmd,
  input  wire       i_event_flags_query_cmd,
  input  wire       i_event_enable_query_cmd,
  input  wire       i_request_enable_query_cmd,
  output reg  [7:0] o_read_data,
  output reg        o_read_valid,
  output wire       o_srq_out,
  output wire       o_srq_oe
);

  // ***************************************************************
  // Operation complete tracking
  // ***************************************************************
  // The command arms a wait; the flag rises once pending work ends
  reg opc_armed;
  wire opc_fire = (opc_armed | i_operation_complete_cmd) & i_pending_done;

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      opc_armed <= 1'b0;
    end else if (opc_fire) begin
      opc_armed <= 1'b0;
    end else if (i_operation_complete_cmd) begin
      opc_armed <= 1'b1;
    end
  end

  // ***************************************************************
  // Power-on marker
  // ***************************************************************
  // Reset stands in for the off-to-on transition; the flag's reset
  // value carries it so it is seen on the first query
  reg power_on_flag_seen;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      power_on_flag_seen <= 1'b0;
    end else begin
      power_on_flag_seen <= 1'b1;
    end
  end

  // ***************************************************************
  // Standard event flags
  // ***************************************************************
  reg  [7:0] event_set;
  wire [7:0] standard_event_flags;

  always @* begin
    event_set = 8'h00;
    event_set[`SSR_EV_POWER_ON]     = 1'b0;
    event_set[`SSR_EV_CMD_FAULT]    = i_command_fault_flag;
    event_set[`SSR_EV_EXEC_FAULT]   = i_execution_fault_flag;
    event_set[`SSR_EV_DEVICE_FAULT] = i_device_fault_flag;
    event_set[`SSR_EV_QUERY_FAULT]  = i_query_fault_flag;
    event_set[`SSR_EV_OPC]          = opc_fire;
  end

  // A query that loses the read arbitration is not answered, so it
  // must not wipe flags the host never saw
  wire event_flags_served = i_event_flags_query_cmd & ~i_serial_poll &
                            ~i_status_byte_query_cmd;

  ssr_sticky #(
    .WIDTH(8)
  ) u_event_flags (
    .i_ref_clk    (i_ref_clk),
    .i_rst        (i_rst),
    .i_set        (event_set),
    .i_clear      (event_flags_served),
    .i_keep_mask  (`SSR_EV_USED_MASK),
    .i_reset_value(`SSR_EV_RESET),
    .o_flags      (standard_event_flags)
  );

  // ***************************************************************
  // Enable masks
  // ***************************************************************
  wire [7:0] request_enable_mask;
  wire [7:0] standard_event_enable_mask;

  ssr_mask_reg #(
    .WIDTH(8)
  ) u_request_enable (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_write    (i_request_enable_write_cmd),
    .i_data     (i_write_data),
    .i_keep_mask(8'hFF),
    .o_mask     (request_enable_mask)
  );

  ssr_mask_reg #(
    .WIDTH(8)
  ) u_event_enable (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_write    (i_event_enable_write_cmd),
    .i_data     (i_write_data),
    .i_keep_mask(8'hFF),
    .o_mask     (standard_event_enable_mask)
  );

  // ***************************************************************
  // Status byte reports
  // ***************************************************************
  wire any_range = i_sensor_over_range | i_temperature_over_range |
                   i_sensor_under_range | i_temperature_under_range;
  // Summary follows enabled events only, so masked events never
  // reach the request through bit 5
  wire event_summary_flag =
    |(standard_event_flags & standard_event_enable_mask);

  reg  [7:0] report_set;
  wire [7:0] report_latched;

  always @* begin
    report_set = 8'h00;
    report_set[`SSR_SB_NEW_READING]   = i_new_reading;
    report_set[`SSR_SB_RANGE]         = any_range;
    report_set[`SSR_SB_ALARM]         = i_alarm_active;
    report_set[`SSR_SB_FAULT]         = i_instrument_fault;
    report_set[`SSR_SB_EVENT_SUMMARY] = event_summary_flag;
    report_set[`SSR_SB_LOG_DONE]      = i_log_done;
  end

  ssr_sticky #(
    .WIDTH(8)
  ) u_report_latch (
    .i_ref_clk    (i_ref_clk),
    .i_rst        (i_rst),
    .i_set        (report_set),
    .i_clear      (i_serial_poll),
    .i_keep_mask  (`SSR_SB_LATCH_MASK),
    .i_reset_value(`SSR_RESET_BYTE),
    .o_flags      (report_latched)
  );

  // ***************************************************************
  // Service request
  // ***************************************************************
  wire [7:0] masked_reports = report_latched & request_enable_mask &
                              `SSR_SB_LATCH_MASK;
  wire request_pending = request_enable_mask[`SSR_SB_REQUEST] &
                         (|masked_reports);
  wire [7:0] summary_status_byte = report_latched |
    ({7'h00, request_pending} << `SSR_SB_REQUEST);

  // Open collector: drive low only, release otherwise
  assign o_srq_out = 1'b0;
  assign o_srq_oe  = request_pending & power_on_flag_seen;

  // ***************************************************************
  // Read port
  // ***************************************************************
  // Value is sampled before the clear that the same strobe triggers
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_read_data  <= `SSR_RESET_BYTE;
      o_read_valid <= 1'b0;
    end else begin
      o_read_valid <= i_serial_poll | i_status_byte_query_cmd |
                      i_event_flags_query_cmd | i_event_enable_query_cmd |
                      i_request_enable_query_cmd;
      if (i_serial_poll) begin
        o_read_data <= summary_status_byte;
      end else if (i_status_byte_query_cmd) begin
        o_read_data <= summary_status_byte;
      end else if (i_event_flags_query_cmd) begin
        o_read_data <= standard_event_flags;
      end else if (i_event_enable_query_cmd) begin
        o_read_data <= standard_event_enable_mask;
      end else if (i_request_enable_query_cmd) begin
        o_read_data <= request_enable_mask;
      end
    end
  end

endmodule

// ### logic/ssr_regs.vh
`ifndef SSR_REGS_VH
`define SSR_REGS_VH
// Status byte bit positions
`define SSR_SB_NEW_READING   0
`define SSR_SB_UNUSED        1
`define SSR_SB_RANGE         2
`define SSR_SB_ALARM         3
`define SSR_SB_FAULT         4
`define SSR_SB_EVENT_SUMMARY 5
`define SSR_SB_REQUEST       6
`define SSR_SB_LOG_DONE      7
// Standard event bit positions
`define SSR_EV_OPC           0
`define SSR_EV_QUERY_FAULT   2
`define SSR_EV_DEVICE_FAULT  3
`define SSR_EV_EXEC_FAULT    4
`define SSR_EV_CMD_FAULT     5
`define SSR_EV_POWER_ON      7
// Masks of implemented bits
`define SSR_SB_LATCH_MASK    8'hBD
`define SSR_EV_USED_MASK     8'hBD
// Reset values
`define SSR_RESET_BYTE       8'h00
`define SSR_EV_RESET         8'h80
`endif

// ### logic/ssr_sticky.v
`timescale 1ns/1ps
// Bank of sticky flags: set wins over clear in the same cycle
module ssr_sticky #(
  parameter WIDTH = 8
) (
  input  wire             i_ref_clk,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_set,
  input  wire             i_clear,
  input  wire [WIDTH-1:0] i_keep_mask,
  input  wire [WIDTH-1:0] i_reset_value,
  output wire [WIDTH-1:0] o_flags
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : bit_gen
      // One variable per bit keeps each flop with a single driver
      reg flag;
      always @(posedge i_ref_clk) begin
        if (i_rst) begin
          flag <= i_reset_value[g];
        end else if (!i_keep_mask[g]) begin
          flag <= 1'b0;
        end else if (i_set[g]) begin
          flag <= 1'b1;
        end else if (i_clear) begin
          flag <= 1'b0;
        end
      end
      assign o_flags[g] = flag;
    end
  endgenerate
endmodule

// ### logic/ssr_mask_reg.v
`timescale 1ns/1ps
// Enable mask register written whole by a command strobe
module ssr_mask_reg #(
  parameter WIDTH = 8
) (
  input  wire             i_ref_clk,
  input  wire             i_rst,
  input  wire             i_write,
  input  wire [WIDTH-1:0] i_data,
  input  wire [WIDTH-1:0] i_keep_mask,
  output reg  [WIDTH-1:0] o_mask
);
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_mask <= {WIDTH{1'b0}};
    end else if (i_write) begin
      o_mask <= i_data & i_keep_mask;
    end
  end
endmodule

// ### sim/ssr_ctrl_model.sv
`timescale 1ns/1ps
// ********************************************************
// Bus controller: polls on request, or when told to
// ********************************************************
module ssr_ctrl_model (
  input  wire i_ref_clk,
  input  wire i_rst,
  input  wire i_srq_oe,
  input  wire i_srq_out,
  input  wire i_auto,
  input  wire i_slow,
  input  wire i_poll_now,
  output reg  o_serial_poll
);
  // Pull-up on the request line while nobody sinks it
  wire      srq_line_n = i_srq_oe ? i_srq_out : 1'b1;
  reg [2:0] gap;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_serial_poll <= 1'b0;
      gap           <= 3'h0;
    end else begin
      o_serial_poll <= 1'b0;
      if (gap != 3'h0) begin
        gap <= gap - 3'h1;
      end else if (i_poll_now || (i_auto && !srq_line_n)) begin
        o_serial_poll <= 1'b1;
        gap           <= i_slow ? 3'h6 : 3'h1;
      end
    end
  end
endmodule

// ### sim/ssr_monitor.sv
`timescale 1ns/1ps
module ssr_monitor (
  input wire       i_ref_clk, i_rst, i_new_reading, i_serial_poll,
  input wire       i_sensor_over_range, i_temperature_over_range,
  input wire       i_sensor_under_range, i_temperature_under_range,
  input wire       i_alarm_active, i_instrument_fault, i_log_done,
  input wire       i_status_byte_query_cmd, i_event_flags_query_cmd,
  input wire       i_event_enable_query_cmd, i_request_enable_query_cmd,
  input wire       i_request_enable_write_cmd, i_event_enable_write_cmd,
  input wire [7:0] i_write_data,
  input wire [7:0] o_read_data,
  input wire       o_read_valid, o_srq_out, o_srq_oe
);
  // Shadow masks, so the request gate is judged from the pins alone
  reg [7:0] rq;
  reg [7:0] ev;
  wire any_rd = i_serial_poll | i_status_byte_query_cmd |
    i_event_flags_query_cmd | i_event_enable_query_cmd |
    i_request_enable_query_cmd;
  wire sb_set = i_new_reading | i_sensor_over_range | i_log_done |
    i_temperature_over_range | i_sensor_under_range | i_alarm_active |
    i_temperature_under_range | i_instrument_fault;
  wire ese_rd = i_event_enable_query_cmd & ~i_serial_poll &
    ~i_status_byte_query_cmd & ~i_event_flags_query_cmd;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      rq <= 8'h00;
      ev <= 8'h00;
    end else begin
      if (i_request_enable_write_cmd) rq <= i_write_data;
      if (i_event_enable_write_cmd) ev <= i_write_data;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  srq_gate_a: assert property (o_srq_oe |-> rq[6])
    else $error("request raised while disabled");
  read_valid_a: assert property (any_rd |=> o_read_valid)
    else $error("read not answered");
  no_read_a: assert property (!any_rd |=> !o_read_valid)
    else $error("answer without read");
  req_bit_a: assert property (i_serial_poll |=>
    o_read_data[6] == $past(o_srq_oe)) else $error("bit 6 wrong");
  unused_bit_a: assert property (o_read_valid &&
    $past(i_serial_poll | i_status_byte_query_cmd) |-> !o_read_data[1])
    else $error("unused bit set");
  mask_echo_a: assert property (ese_rd |=>
    o_read_data == $past(ev)) else $error("event mask readback wrong");
  new_rdg_a: assert property (i_new_reading ##1
    i_status_byte_query_cmd |=> o_read_data[0])
    else $error("new reading lost");
  query_keep_a: assert property (i_status_byte_query_cmd &&
    !i_serial_poll && !i_request_enable_write_cmd && o_srq_oe |=> o_srq_oe)
    else $error("query cleared status");
  poll_clear_a: assert property (i_serial_poll && !sb_set &&
    ev == 8'h00 |=> !o_srq_oe) else $error("poll left request");
  cover property (o_srq_oe);
  cover property (i_serial_poll && o_srq_oe);
  cover property (i_event_flags_query_cmd ##1 o_read_valid);
endmodule
bind ssr_status_request ssr_monitor u_mon (.*);

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, auto = 1'b0, slow = 1'b0, poll_now;
  logic i_new_reading, i_sensor_over_range, i_temperature_over_range;
  logic i_sensor_under_range, i_temperature_under_range, i_alarm_active;
  logic i_instrument_fault, i_log_done, i_command_fault_flag;
  logic i_execution_fault_flag, i_device_fault_flag, i_query_fault_flag;
  logic i_operation_complete_cmd, i_pending_done, i_event_enable_write_cmd;
  logic i_request_enable_write_cmd, i_status_byte_query_cmd;
  logic i_event_flags_query_cmd, i_event_enable_query_cmd;
  logic i_request_enable_query_cmd;
  logic [7:0] i_write_data = 8'h00;
  wire i_serial_poll, o_read_valid, o_srq_out, o_srq_oe;
  wire [7:0] o_read_data;
  integer seed = 7, miscompares = 0, checks = 0, ph;
  reg [7:0] sb, evf, rq, ev, exp_data, sset, eset;
  reg armed, exp_valid;
  ssr_status_request dut (.*);
  ssr_ctrl_model u_ctrl (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_srq_oe(o_srq_oe), .i_srq_out(o_srq_out), .i_auto(auto),
    .i_slow(slow), .i_poll_now(poll_now), .o_serial_poll(i_serial_poll));
  function pend(input [7:0] s, input [7:0] r);
    pend = r[6] & |(s & r & 8'hBF);
  endfunction
  task set_in(input [21:0] v);
    {i_new_reading, i_sensor_over_range, i_temperature_over_range,
     i_sensor_under_range, i_temperature_under_range, i_alarm_active,
     i_instrument_fault, i_log_done, i_command_fault_flag,
     i_execution_fault_flag, i_device_fault_flag, i_query_fault_flag,
     i_operation_complete_cmd, i_pending_done, i_request_enable_write_cmd,
     i_event_enable_write_cmd, i_status_byte_query_cmd,
     i_event_flags_query_cmd, i_event_enable_query_cmd,
     i_request_enable_query_cmd, poll_now} = v[21:1];
    @(posedge i_ref_clk);
    #1;
  endtask
  task rnd;
    reg [21:0] v;
    integer k;
    v = $random(seed) & $random(seed) & $random(seed);
    v[8] = $random(seed);
    k = $random(seed) & 7;
    v[5:2] = (k < 4) ? 4'h1 << k : 4'h0;
    i_write_data = $random(seed);
    set_in(v);
  endtask
  task chk_byte(input string n, input [7:0] e, input [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_bit(input string n, input e, input g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  task close_out;
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ********************************************************
  // Reference of the status layers
  // ********************************************************
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      {sb, rq, ev, exp_data, armed, exp_valid} = 0;
      evf = 8'h80;
    end else begin
      sset = {i_log_done, 1'b0, |(evf & ev), i_instrument_fault,
        i_alarm_active, i_sensor_over_range | i_temperature_over_range |
        i_sensor_under_range | i_temperature_under_range, 1'b0,
        i_new_reading};
      eset = {2'b00, i_command_fault_flag, i_execution_fault_flag,
        i_device_fault_flag, i_query_fault_flag, 1'b0,
        (armed | i_operation_complete_cmd) & i_pending_done};
      armed = (armed | i_operation_complete_cmd) & ~i_pending_done;
      exp_valid = i_serial_poll | i_status_byte_query_cmd |
        i_event_flags_query_cmd | i_event_enable_query_cmd |
        i_request_enable_query_cmd;
      if (i_serial_poll | i_status_byte_query_cmd)
        exp_data = (sb & 8'hBD) | {1'b0, pend(sb, rq), 6'h00};
      else if (i_event_flags_query_cmd) begin
        exp_data = evf;
        evf = 8'h00;
      end else if (i_event_enable_query_cmd) exp_data = ev;
      else if (i_request_enable_query_cmd) exp_data = rq;
      sb = (i_serial_poll ? 8'h00 : sb) | sset;
      evf = evf | eset;
      if (i_request_enable_write_cmd) rq = i_write_data;
      if (i_event_enable_write_cmd) ev = i_write_data;
    end
  end
  always @(negedge i_ref_clk) begin
    if (!i_rst) begin
      chk_bit("read_valid", exp_valid, o_read_valid);
      if (exp_valid) chk_byte("read_data", exp_data, o_read_data);
      chk_bit("srq_oe", pend(sb, rq), o_srq_oe);
      chk_bit("srq_out", 1'b0, o_srq_out);
    end
  end
  initial forever #5 i_ref_clk = ~i_ref_clk;
  initial begin
    #300000;
    miscompares++;
    close_out;
  end
  initial begin
    set_in(22'h0);
    set_in(22'h0);
    i_rst = 1'b0;
    // Back-to-back event flag reads: power-on bit, then cleared
    set_in(22'h10);
    set_in(22'h10);
    i_write_data = 8'h48;
    set_in(22'h80);
    set_in(22'h10000);
    // Forced poll of the pending alarm with no new sets
    set_in(22'h2);
    repeat (4) set_in(22'h0);
    for (ph = 0; ph < 8; ph++) begin
      auto = ph[0];
      slow = ph[1];
      i_rst = (ph == 4);
      repeat (1500) rnd;
    end
    close_out;
  end
endmodule
